// ### wave_noload_params.svh
// constants for waveform select and no-load configuration block
// Functional notes
// - second source field bits 7..5 selects current, voltage, powers, rms; others reserved
// - first source field bits 4..2 uses the same six-code source encoding
// - first source rms selection outputs only the lower 24 bits
// - reactive product source usable only on variants with reactive measurement
// - sample rate divides core/5 base clock by 32, 64, 128 or 256
// - no-load bit 7 turns off reactive gain compensation over line frequency
// - no-load bit 6 applies no-load detection to rms current with apparent threshold
// - apparent field: 00 off, else 0.030%, 0.015%, 0.0075% of full scale
// - reactive field: 00 off, else 0.015%, 0.0075%, 0.0037% of full scale
// - active field: 00 off, else 0.015%, 0.0075%, 0.0037% of full scale
// - samples are produced only while the wave sampling enable is set
`ifndef WAVE_NOLOAD_PARAMS_SVH
`define WAVE_NOLOAD_PARAMS_SVH
`define WSR_INDEX 8'h0D
`define NLC_INDEX 8'h0E
`define MODE2_ADDR 8'h40
`define WSR_ADDR 8'h34
`define NLC_ADDR 8'h38
`define WSR_RESET 8'h00
`define NLC_RESET 8'h00
`define MODE2_RESET 8'h00
`define WAVE_EN_BIT 0
`define SRC_CURRENT 3'h0
`define SRC_VOLTAGE 3'h1
`define SRC_ACTIVE 3'h2
`define SRC_REACTIVE 3'h3
`define SRC_APPARENT 3'h4
`define SRC_RMS 3'h5
`define CORE_DIV 3'h4
`define RATE_SHIFT_BASE 4'h5
`define THR_FS_30 24'h00_00FB
`define THR_FS_15 24'h00_007D
`define THR_FS_7 24'h00_003E
`define THR_FS_3 24'h00_001F
`define LOW24_MASK 32'h00FF_FFFF
`endif

// ### wave_noload_pkg.sv
// types for waveform select and no-load configuration block
package wave_noload_pkg;
  typedef struct packed {
    logic [2:0] second_wave_source;
    logic [2:0] first_wave_source;
    logic [1:0] sample_rate_code;
  } wave_cfg_t;
  typedef struct packed {
    logic reactive_comp_disable;
    logic current_rms_noload_enable;
    logic [1:0] apparent_noload_threshold;
    logic [1:0] reactive_noload_threshold;
    logic [1:0] active_noload_threshold;
  } noload_cfg_t;
  typedef struct packed {
    logic [31:0] current;
    logic [31:0] voltage;
    logic [31:0] active;
    logic [31:0] reactive;
    logic [31:0] apparent;
    logic [31:0] rms;
  } dsp_sources_t;
  typedef struct packed {
    logic active_zero;
    logic reactive_zero;
    logic apparent_zero;
    logic rms_zero;
  } noload_flags_t;
endpackage : wave_noload_pkg

// ### noload_detect.sv
// one no-load comparator: threshold from 2-bit code, flag when below
`include "wave_noload_params.svh"
module noload_detect (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // code and magnitude
  input wire logic [1:0] code,
  input wire logic apparent_table,
  input wire logic [23:0] magnitude,
  // result
  output logic below
);
  logic [23:0] thr;
  logic below_next;
  function automatic logic [23:0] pick_thr(input logic [1:0] c, input logic app);
    logic [23:0] t;
    t = `THR_FS_3;
    case (c)
      2'h1: t = app ? `THR_FS_30 : `THR_FS_15;
      2'h2: t = app ? `THR_FS_15 : `THR_FS_7;
      default: t = app ? `THR_FS_7 : `THR_FS_3;
    endcase
    return t;
  endfunction : pick_thr
  assign thr = pick_thr(code, apparent_table);
  assign below_next = (code != 2'h0) && (magnitude < thr);
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      below <= 1'b0;
    end else begin
      below <= below_next;
    end
  end
endmodule : noload_detect

// ### wave_noload_config.sv
// waveform select, sample rate and no-load configuration with wishbone slave
//
// Our own choice: the Wishbone register port.
`include "wave_noload_params.svh"
module wave_noload_config
  import wave_noload_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic WB_ERR_O,
  // dsp sources and magnitudes
  input wire wave_noload_pkg::dsp_sources_t SRC,
  input wire logic VAR_SUPPORTED,
  // waveform outputs
  output logic [31:0] WAVE1_DATA,
  output logic [31:0] WAVE2_DATA,
  output logic WAVE_STROBE,
  // configuration outputs
  output logic REACTIVE_COMP_OFF,
  output wave_noload_pkg::noload_flags_t NOLOAD
);
  import wave_noload_pkg::*;

  wave_cfg_t wsr_reg;
  noload_cfg_t nlc_reg;
  logic [7:0] mode2_reg;
  logic ack_reg, ack_next, err_reg, err_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [2:0] pre_reg, pre_next;
  logic [7:0] rate_reg, rate_next;
  logic [31:0] w1_reg, w1_next, w2_reg, w2_next;
  logic strobe_reg, strobe_next;
  logic comp_off_reg;
  noload_flags_t flags;

  // bus decode
  wire req = WB_CYC_I && WB_STB_I && !ack_reg && !err_reg;
  wire hit_wsr = WB_ADR_I == `WSR_ADDR;
  wire hit_nlc = WB_ADR_I == `NLC_ADDR;
  wire hit_mode2 = WB_ADR_I == `MODE2_ADDR;
  wire mapped = hit_wsr || hit_nlc || hit_mode2;
  // write commits on the ack edge, while the master still holds the request
  wire wr_lane0 = ack_reg && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0];
  wire wave_enable = mode2_reg[`WAVE_EN_BIT];

  assign ack_next = req && mapped;
  assign err_next = req && !mapped;
  assign rdat_next = !req ? 32'h0000_0000 :
    hit_wsr ? {24'h00_0000, wsr_reg} :
    hit_nlc ? {24'h00_0000, nlc_reg} :
    hit_mode2 ? {24'h00_0000, mode2_reg} : 32'h0000_0000;

  // source selection, reactive masked where unsupported
  function automatic logic [31:0] pick_src(input logic [2:0] sel, input dsp_sources_t s,
                                           input logic var_ok, input logic first);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (sel)
      `SRC_CURRENT: v = s.current;
      `SRC_VOLTAGE: v = s.voltage;
      `SRC_ACTIVE: v = s.active;
      `SRC_REACTIVE: v = var_ok ? s.reactive : 32'h0000_0000;
      `SRC_APPARENT: v = s.apparent;
      `SRC_RMS: v = first ? (s.rms & `LOW24_MASK) : s.rms;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : pick_src

  // base tick at core/5, then divide by 32..256
  wire base_tick = pre_reg == `CORE_DIV;
  assign pre_next = base_tick ? 3'h0 : pre_reg + 3'h1;
  wire [3:0] rate_shift = `RATE_SHIFT_BASE + {2'h0, wsr_reg.sample_rate_code};
  wire [8:0] rate_len = 9'h001 << rate_shift;
  wire rate_wrap = base_tick && ({1'b0, rate_reg} == rate_len - 9'h001);
  assign rate_next = !wave_enable ? 8'h00 :
    base_tick ? (rate_wrap ? 8'h00 : rate_reg + 8'h01) : rate_reg;
  assign strobe_next = wave_enable && rate_wrap;
  assign w1_next = strobe_next ? pick_src(wsr_reg.first_wave_source, SRC, VAR_SUPPORTED, 1'b1)
                               : w1_reg;
  assign w2_next = strobe_next ? pick_src(wsr_reg.second_wave_source, SRC, VAR_SUPPORTED, 1'b0)
                               : w2_reg;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wsr_reg <= `WSR_RESET;
      nlc_reg <= `NLC_RESET;
      mode2_reg <= `MODE2_RESET;
    end else begin
      if (wr_lane0 && hit_wsr) wsr_reg <= WB_DAT_I[7:0];
      if (wr_lane0 && hit_nlc) nlc_reg <= WB_DAT_I[7:0];
      if (wr_lane0 && hit_mode2) mode2_reg <= WB_DAT_I[7:0];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= ack_next;
      err_reg <= err_next;
      rdat_reg <= rdat_next;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pre_reg <= 3'h0;
      rate_reg <= 8'h00;
      w1_reg <= 32'h0000_0000;
      w2_reg <= 32'h0000_0000;
      strobe_reg <= 1'b0;
      comp_off_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      rate_reg <= rate_next;
      w1_reg <= w1_next;
      w2_reg <= w2_next;
      strobe_reg <= strobe_next;
      comp_off_reg <= nlc_reg.reactive_comp_disable;
    end
  end

  // no-load comparators: active, reactive, apparent, rms current
  noload_detect u_active (.CLK(CLK), .RST(RST), .code(nlc_reg.active_noload_threshold),
    .apparent_table(1'b0), .magnitude(SRC.active[23:0]), .below(flags.active_zero));
  noload_detect u_reactive (.CLK(CLK), .RST(RST), .code(nlc_reg.reactive_noload_threshold),
    .apparent_table(1'b0), .magnitude(SRC.reactive[23:0]),
    .below(flags.reactive_zero));
  noload_detect u_apparent (.CLK(CLK), .RST(RST), .code(nlc_reg.apparent_noload_threshold),
    .apparent_table(1'b1), .magnitude(SRC.apparent[23:0]),
    .below(flags.apparent_zero));
  noload_detect u_rms (.CLK(CLK), .RST(RST),
    .code(nlc_reg.current_rms_noload_enable ? nlc_reg.apparent_noload_threshold : 2'h0),
    .apparent_table(1'b1), .magnitude(SRC.rms[23:0]), .below(flags.rms_zero));

  // flags hold accumulation and pulses at zero downstream
  assign NOLOAD = flags;
  assign WB_ACK_O = ack_reg;
  assign WB_ERR_O = err_reg;
  assign WB_DAT_O = rdat_reg;
  assign WAVE1_DATA = w1_reg;
  assign WAVE2_DATA = w2_reg;
  assign WAVE_STROBE = strobe_reg;
  assign REACTIVE_COMP_OFF = comp_off_reg;

  // checks
  strobe_needs_en_a: assert property (@(posedge CLK) disable iff (RST)
    WAVE_STROBE |-> $past(wave_enable)) else $error("strobe without sampling enable");
  rms_low24_a: assert property (@(posedge CLK) disable iff (RST)
    (strobe_next && wsr_reg.first_wave_source == `SRC_RMS) |=> WAVE1_DATA[31:24] == 8'h00)
    else $error("first rms sample not limited to 24 bits");
  reactive_gate_a: assert property (@(posedge CLK) disable iff (RST)
    (strobe_next && !VAR_SUPPORTED && wsr_reg.second_wave_source == `SRC_REACTIVE)
    |=> WAVE2_DATA == 32'h0000_0000) else $error("reactive source on unsupported variant");
  src_current_a: assert property (@(posedge CLK) disable iff (RST)
    (strobe_next && wsr_reg.second_wave_source == `SRC_CURRENT)
    |=> WAVE2_DATA == $past(SRC.current)) else $error("second source current wrong");
  src_voltage_a: assert property (@(posedge CLK) disable iff (RST)
    (strobe_next && wsr_reg.first_wave_source == `SRC_VOLTAGE)
    |=> WAVE1_DATA == $past(SRC.voltage)) else $error("first source voltage wrong");
  rate_min_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(WAVE_STROBE) |=> !WAVE_STROBE [*8]) else $error("sample rate too fast");
  comp_follow_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(nlc_reg.reactive_comp_disable) |=> REACTIVE_COMP_OFF)
    else $error("compensation disable not applied");
  noload_off_a: assert property (@(posedge CLK) disable iff (RST)
    (nlc_reg.active_noload_threshold == 2'h0) |=> !NOLOAD.active_zero)
    else $error("active no-load flagged while disabled");
  rms_off_a: assert property (@(posedge CLK) disable iff (RST)
    !nlc_reg.current_rms_noload_enable |=> !NOLOAD.rms_zero)
    else $error("rms no-load flagged while disabled");
  apparent_off_a: assert property (@(posedge CLK) disable iff (RST)
    (nlc_reg.apparent_noload_threshold == 2'h0) |=> !NOLOAD.apparent_zero)
    else $error("apparent no-load flagged while disabled");
  reactive_off_a: assert property (@(posedge CLK) disable iff (RST)
    (nlc_reg.reactive_noload_threshold == 2'h0) |=> !NOLOAD.reactive_zero)
    else $error("reactive no-load flagged while disabled");
  ack_once_a: assert property (@(posedge CLK) disable iff (RST)
    WB_ACK_O |=> !WB_ACK_O) else $error("ack held two cycles");
  err_once_a: assert property (@(posedge CLK) disable iff (RST)
    WB_ERR_O |=> !WB_ERR_O) else $error("err held two cycles");
  ack_err_excl_a: assert property (@(posedge CLK) disable iff (RST)
    !(WB_ACK_O && WB_ERR_O)) else $error("ack and err together");
  src_rms_a: assert property (@(posedge CLK) disable iff (RST)
    (strobe_next && wsr_reg.second_wave_source == `SRC_RMS)
    |=> WAVE2_DATA == $past(SRC.rms)) else $error("second source rms wrong");
  reserved_zero_a: assert property (@(posedge CLK) disable iff (RST)
    (strobe_next && wsr_reg.first_wave_source > `SRC_RMS)
    |=> WAVE1_DATA == 32'h0000_0000) else $error("reserved first source not zero");
  active_below_a: assert property (@(posedge CLK) disable iff (RST)
    (nlc_reg.active_noload_threshold == 2'h1 && SRC.active[23:0] < `THR_FS_15)
    |=> NOLOAD.active_zero) else $error("active below threshold not flagged");
  apparent_below_a: assert property (@(posedge CLK) disable iff (RST)
    (nlc_reg.apparent_noload_threshold == 2'h1 && SRC.apparent[23:0] < `THR_FS_30)
    |=> NOLOAD.apparent_zero) else $error("apparent below threshold not flagged");
  reactive_below_a: assert property (@(posedge CLK) disable iff (RST)
    (nlc_reg.reactive_noload_threshold == 2'h2 && SRC.reactive[23:0] < `THR_FS_7)
    |=> NOLOAD.reactive_zero) else $error("reactive below threshold not flagged");
  rms_below_a: assert property (@(posedge CLK) disable iff (RST)
    (nlc_reg.current_rms_noload_enable && nlc_reg.apparent_noload_threshold == 2'h1
    && SRC.rms[23:0] < `THR_FS_30) |=> NOLOAD.rms_zero)
    else $error("rms below threshold not flagged");
  noload_hold_a: assert property (@(posedge CLK) disable iff (RST)
    NOLOAD.active_zero |-> $past(SRC.active[23:0]) < `THR_FS_15)
    else $error("active held at zero above every threshold");
endmodule : wave_noload_config

// ### testbench.sv
// self-checking bench for the waveform select and no-load configuration block
`include "wave_noload_params.svh"
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import wave_noload_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, var_ok = 1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, w1, w2;
  logic ack, err, strobe, comp_off, er;
  logic [31:0] bus_rdat;
  dsp_sources_t src = '0;
  noload_flags_t nl;
  int errors = 0, n_compared = 0, ticks = 0, p;
  wave_noload_config u_dut (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(bus_rdat),
    .WB_ACK_O(ack), .WB_ERR_O(err), .SRC(src), .VAR_SUPPORTED(var_ok),
    .WAVE1_DATA(w1), .WAVE2_DATA(w2), .WAVE_STROBE(strobe),
    .REACTIVE_COMP_OFF(comp_off), .NOLOAD(nl));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic tally_and_finish;
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    ticks++;
    if (ticks == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  // one classic cycle; holds until ack or err is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1 && err !== 1'b1);
    r = bus_rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input logic ee);
    logic [31:0] r;
    logic e;
    wb(0, a, 32'h0000_0000, 4'hF, r, e);
    `CHK("read data", ex, r)
    `CHK("error flag", ee, e)
  endtask : rd_chk
  // returns cycles from the call to the next strobe sample, at most 3000
  task automatic next_strobe(output int n);
    n = 0;
    do begin @(posedge clk); n++; end while (strobe !== 1'b1 && n < 3000);
  endtask : next_strobe
  function automatic logic [31:0] pick(input logic [2:0] c, input logic first);
    case (c)
      `SRC_CURRENT: return src.current;
      `SRC_VOLTAGE: return src.voltage;
      `SRC_ACTIVE: return src.active;
      `SRC_REACTIVE: return var_ok ? src.reactive : 32'h0000_0000;
      `SRC_APPARENT: return src.apparent;
      `SRC_RMS: return first ? (src.rms & `LOW24_MASK) : src.rms;
      default: return 32'h0000_0000;
    endcase
  endfunction : pick
  initial begin
    src = {32'h1111_1111, 32'h2222_2222, 32'h3333_3333, 32'h4444_4444,
           32'h5555_5555, 32'hA6A6_A6A6};
    repeat (3) @(posedge clk);
    rst <= 0;
    rd_chk(`WSR_ADDR, 32'h0000_0000, 0);
    rd_chk(`NLC_ADDR, 32'h0000_0000, 0);
    rd_chk(`MODE2_ADDR, 32'h0000_0000, 0);
    wb(1, `WSR_ADDR, 32'h0000_00A5, 4'h0, rdat, er);
    rd_chk(`WSR_ADDR, 32'h0000_0000, 0);
    rd_chk(8'h3C, 32'h0000_0000, 1);
    wb(1, 8'h3C, 32'h0000_00FF, 4'h1, rdat, er);
    `CHK("unmapped write err", 1'b1, er)
    wb(1, `MODE2_ADDR, 32'h0000_0001, 4'h1, rdat, er);
    for (int c = 0; c < 8; c++) begin
      wb(1, `WSR_ADDR, {24'h0, c[2:0], c[2:0], 2'b00}, 4'h1, rdat, er);
      rd_chk(`WSR_ADDR, {24'h0, c[2:0], c[2:0], 2'b00}, 0);
      next_strobe(p);
      next_strobe(p);
      `CHK("first wave", pick(c[2:0], 1), w1)
      `CHK("second wave", pick(c[2:0], 0), w2)
    end
    var_ok <= 0;
    wb(1, `WSR_ADDR, 32'h0000_006C, 4'h1, rdat, er);
    next_strobe(p);
    next_strobe(p);
    `CHK("reactive off wave", 32'h0000_0000, w1)
    `CHK("reactive off wave 2", 32'h0000_0000, w2)
    for (int r = 0; r < 4; r++) begin
      wb(1, `WSR_ADDR, {30'h0, r[1:0]}, 4'h1, rdat, er);
      next_strobe(p);
      next_strobe(p);
      `CHK("strobe period", 5 * (32 << r), p)
    end
    wb(1, `MODE2_ADDR, 32'h0000_0000, 4'h1, rdat, er);
    next_strobe(p);
    `CHK("no strobe when off", 3000, p)
    src.active <= 32'h0000_007C;
    src.reactive <= 32'h0000_001F;
    src.apparent <= 32'h0000_00FA;
    src.rms <= 32'h0000_00FB;
    wb(1, `NLC_ADDR, 32'h0000_00DD, 4'h1, rdat, er);
    repeat (3) @(posedge clk);
    `CHK("comp off", 1'b1, comp_off)
    `CHK("noload flags", 4'b1010, nl)
    src.rms <= 32'h0000_00FA;
    wb(1, `NLC_ADDR, 32'h0000_005A, 4'h1, rdat, er);
    repeat (3) @(posedge clk);
    `CHK("comp on", 1'b0, comp_off)
    `CHK("noload flags 2", 4'b0111, nl)
    wb(1, `NLC_ADDR, 32'h0000_0000, 4'h1, rdat, er);
    repeat (3) @(posedge clk);
    `CHK("noload disabled", 4'b0000, nl)
    tally_and_finish();
  end
endmodule : testbench
